// ==== hdl/rpv_panel_input.v ====
// Panel side of the parallel RGB video input: sampling, positioning, pixel word
`timescale 1ns/1ps
`include "rpv_timing_map.vh"

module rpv_panel_input #(
    parameter ACTIVE_PIXELS = `RPV_ACTIVE_PIXELS_PER_LINE,
    parameter FIRST_LINE    = `RPV_FIRST_ACTIVE_LINE,
    parameter ACTIVE_LINES  = `RPV_ACTIVE_LINES
) (
    input  wire        clk_in,
    input  wire        rstn_in,
    input  wire        pixel_clock_in,
    input  wire        line_sync_n_in,
    input  wire        frame_sync_n_in,
    input  wire        data_enable_strobe_in,
    input  wire [5:0]  red_level_in,
    input  wire [5:0]  green_level_in,
    input  wire [5:0]  blue_level_in,
    input  wire        h_mirror_in,
    input  wire        v_normal_in,
    output reg         pixel_valid_out,
    output reg  [17:0] pixel_word_out,
    output reg  [8:0]  pixel_column_out,
    output reg  [8:0]  pixel_row_out,
    output reg         frame_start_out,
    output reg         line_overrun_out,
    output reg         enable_short_out
);
    // Pixel clock and all panel pins share one synchroniser so data stays aligned to its edge
    localparam SW = 1 + 1 + 1 + 1 + 18 + 2;
    wire [SW-1:0] sync_w;

    rpv_sync2 #(.WIDTH(SW)) u_sync (
        .clk_in  (clk_in),
        .rstn_in (rstn_in),
        .d_in    ({pixel_clock_in, line_sync_n_in, frame_sync_n_in, data_enable_strobe_in,
                   red_level_in, green_level_in, blue_level_in, h_mirror_in, v_normal_in}),
        .q_out   (sync_w)
    );

    wire        pck_s  = sync_w[23];
    wire        hs_n_s = sync_w[22];
    wire        vs_n_s = sync_w[21];
    wire        de_s   = sync_w[20];
    wire [17:0] rgb_s  = sync_w[19:2];
    wire        hmir_s = sync_w[1];
    wire        vnor_s = sync_w[0];

    reg        pck_q;
    reg        hs_q;
    reg        vs_q;
    reg        de_q;
    reg [8:0]  col_q;
    reg [8:0]  line_q;
    reg        vs_seen_q;
    reg [1:0]  win_state_q;
    reg [1:0]  win_state_d;
    reg [8:0]  col_d;
    reg        short_d;

    // Panel samples on the rising pixel clock edge
    wire       tick = pck_s & ~pck_q;
    wire       hs   = ~hs_n_s;
    wire       vs   = ~vs_n_s;
    wire       hs_rise = tick & hs & ~hs_q;
    wire       vs_rise = tick & vs & ~vs_q;
    wire       de_rise = tick & de_s & ~de_q;

    function [8:0] mirror;
        input [8:0] idx;
        input [8:0] span;
        input       flip;
        begin
            mirror = flip ? (span - 9'd1 - idx) : idx;
        end
    endfunction

    // Counts are cut to the 9-bit counters on purpose; 320 columns and 511 lines fit
    localparam [31:0] LAST_COL_W = ACTIVE_PIXELS - 1;
    localparam [31:0] FIRST_LN_W = FIRST_LINE;
    localparam [31:0] N_LINES_W  = ACTIVE_LINES;
    localparam [31:0] N_PIXELS_W = ACTIVE_PIXELS;
    localparam [8:0]  LAST_COL   = LAST_COL_W[8:0];
    localparam [8:0]  FIRST_LN   = FIRST_LN_W[8:0];
    localparam [8:0]  N_LINES    = N_LINES_W[8:0];
    localparam [8:0]  N_PIXELS   = N_PIXELS_W[8:0];

    // Horizontal window states
    localparam [1:0]  WIN_IDLE   = 2'b01;
    localparam [1:0]  WIN_OPEN   = 2'b10;

    wire       win_open = (win_state_q == WIN_OPEN);

    // Row index counted from line FIRST_LINE after the frame start, independent of enable
    wire [8:0] row_raw = line_q - FIRST_LN;
    wire       row_ok  = vs_seen_q && (line_q >= FIRST_LN) && (row_raw < N_LINES);

    // Pin history: pixel clock taken every clock, other pins once per pixel clock so edges are seen in pixel time
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pck_q <= 1'b0;
            hs_q  <= 1'b0;
            vs_q  <= 1'b0;
            de_q  <= 1'b0;
        end else begin
            pck_q <= pck_s;
            if (tick) begin
                hs_q <= hs;
                vs_q <= vs;
                de_q <= de_s;
            end
        end
    end

    // Frame sync resets the line count; a line sync in the same clock is not counted
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            line_q    <= 9'h000;
            vs_seen_q <= 1'b0;
        end else if (vs_rise) begin
            line_q    <= 9'h000;
            vs_seen_q <= 1'b1;
        end else if (hs_rise && line_q != 9'h1ff) begin
            // Saturates so a missing frame sync cannot wrap into the active rows
            line_q <= line_q + 9'd1;
        end
    end

    // Window opens on the enable edge and runs a fixed count, so a long enable adds nothing
    always @* begin
        win_state_d = win_state_q;
        col_d       = col_q;
        short_d     = 1'b0;
        if (tick) begin
            case (win_state_q)
                WIN_IDLE: begin
                    if (de_rise) begin
                        win_state_d = (N_PIXELS != 9'd1) ? WIN_OPEN : WIN_IDLE;
                        col_d       = 9'h001;
                    end
                end
                WIN_OPEN: begin
                    if (de_rise) begin
                        win_state_d = (N_PIXELS != 9'd1) ? WIN_OPEN : WIN_IDLE;
                        col_d       = 9'h001;
                    end else if (!de_s) begin
                        win_state_d = WIN_IDLE;
                        short_d     = 1'b1;
                        col_d       = col_q + 9'd1;
                    end else begin
                        if (col_q == LAST_COL) begin
                            win_state_d = WIN_IDLE;
                        end
                        col_d = col_q + 9'd1;
                    end
                end
                default: begin
                    win_state_d = WIN_IDLE;
                end
            endcase
        end
    end

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            win_state_q <= WIN_IDLE;
            col_q       <= 9'h000;
        end else begin
            win_state_q <= win_state_d;
            col_q       <= col_d;
        end
    end

    // Registered outputs; data holds between pixels so a slow consumer may read it late
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pixel_valid_out  <= 1'b0;
            pixel_word_out   <= 18'h00000;
            pixel_column_out <= 9'h000;
            pixel_row_out    <= 9'h000;
            frame_start_out  <= 1'b0;
            line_overrun_out <= 1'b0;
            enable_short_out <= 1'b0;
        end else begin
            pixel_valid_out  <= 1'b0;
            frame_start_out  <= vs_rise;
            enable_short_out <= short_d;
            line_overrun_out <= hs_rise && win_open;
            if (tick && (de_rise || (win_open && de_s)) && row_ok) begin
                pixel_valid_out  <= 1'b1;
                pixel_word_out   <= rgb_s;
                pixel_column_out <= mirror(de_rise ? 9'h000 : col_q, N_PIXELS, hmir_s);
                pixel_row_out    <= mirror(row_raw, N_LINES, ~vnor_s);
            end
        end
    end
endmodule // rpv_panel_input

// ==== hdl/rpv_sync2.v ====
// Two-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module rpv_sync2 #(
    parameter WIDTH = 1
) (
    input  wire             clk_in,
    input  wire             rstn_in,
    input  wire [WIDTH-1:0] d_in,
    output wire [WIDTH-1:0] q_out
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= d_in;
            sync_q <= meta_q;
        end
    end

    assign q_out = sync_q;
endmodule // rpv_sync2

// ==== hdl/rpv_timing_map.vh ====
// Timing constants of the panel video input
`ifndef RPV_TIMING_MAP_VH
`define RPV_TIMING_MAP_VH
`define RPV_ACTIVE_PIXELS_PER_LINE 320
`define RPV_ENABLE_OFFSET          7
`define RPV_FIRST_ACTIVE_LINE      7
`define RPV_ACTIVE_LINES           240
`define RPV_LINE_PERIOD_MIN        360
`define RPV_LINE_PERIOD_TYP        400
`define RPV_LINE_PERIOD_MAX        450
`define RPV_FRAME_PERIOD_MIN       251
`define RPV_FRAME_PERIOD_TYP       262
`define RPV_FRAME_PERIOD_MAX       280
`define RPV_SYNC_WIDTH_MIN         1
`define RPV_SYNC_WIDTH_MAX         6
`define RPV_MAX_SKEW               320
`define RPV_PIXEL_CLOCK_MAX_KHZ    7000
`define RPV_CLK_IN_KHZ             200000
`define RPV_COLOUR_BITS            6
`define RPV_PIXEL_BITS             18
`endif

// ==== testbench/rpv_ctl_model.sv ====
// Display controller model driving the panel timing pins
`timescale 1ns/1ps
module rpv_ctl_model (
    input  wire       clk_in,
    input  wire       rstn_in,
    output wire [3:0] pins_out,
    output reg  [3:0] ln_out
);
    reg  [12:0] t_q;
    wire [8:0]  px = t_q[12:4];
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            t_q    <= 13'h15e0;
            ln_out <= 4'h8;
        end else begin
            t_q <= (t_q == 13'h167f) ? 13'h0 : t_q + 13'h1;
            // Nine-line frames and a fast pixel clock keep the run short, outside the panel's limits
            if (t_q == 13'h167f) ln_out <= (ln_out == 4'h8) ? 4'h0 : ln_out + 4'h1;
        end
    end
    // Pins move on the falling pixel edge, half a period clear of the sampling rise
    assign pins_out = {t_q[3], px > 9'h1, ln_out != 4'h0,
                       px > 9'h6 && px < 9'h148};
endmodule // rpv_ctl_model

// ==== testbench/rpv_props.sv ====
// Port relation checks of the panel video input
`timescale 1ns/1ps
module rpv_props #(parameter ACTIVE_LINES = 240) (
    input wire        clk_in, rstn_in, pixel_clock_in, frame_sync_n_in, data_enable_strobe_in,
    input wire        h_mirror_in, pixel_valid_out, frame_start_out,
    input wire [5:0]  red_level_in, green_level_in, blue_level_in,
    input wire [17:0] pixel_word_out,
    input wire [8:0]  pixel_column_out, pixel_row_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    sequence s_two_pixels;
        pixel_valid_out ##16 pixel_valid_out;
    endsequence
    a_valid_pulse: assert property (pixel_valid_out |=> !pixel_valid_out) else $error("valid too wide");
    a_at_clock_rise: assert property (pixel_valid_out |-> $past(pixel_clock_in, 3) &&
        !($past(pixel_clock_in, 4) && $past(pixel_clock_in, 5))) else $error("valid off rise");
    a_word_taken: assert property (pixel_valid_out |->
        pixel_word_out == $past({red_level_in, green_level_in, blue_level_in}, 4)) else $error("bad word");
    a_in_window: assert property (pixel_valid_out |-> $past(data_enable_strobe_in, 4) &&
        pixel_column_out < 9'd320 && pixel_row_out < ACTIVE_LINES) else $error("outside window");
    a_first_column: assert property (pixel_valid_out && !$past(data_enable_strobe_in, 20) |->
        pixel_column_out == (h_mirror_in ? 9'd319 : 9'd0)) else $error("bad first column");
    a_column_step: assert property (s_two_pixels |->
        pixel_column_out == $past(pixel_column_out, 16) + (h_mirror_in ? 9'h1ff : 9'h1)) else $error("bad step");
    a_outputs_hold: assert property (!pixel_valid_out |-> $stable(pixel_word_out) && $stable(pixel_row_out) &&
        $stable(pixel_column_out))
        else $error("output moved");
    a_frame_start: assert property (frame_start_out |-> !$past(frame_sync_n_in, 3) && $past(frame_sync_n_in, 19)
        ##1 !frame_start_out [*8]) else $error("bad frame start");
endmodule // rpv_props
bind rpv_panel_input rpv_props #(.ACTIVE_LINES(ACTIVE_LINES)) u_props (.*);

// ==== testbench/testbench.sv ====
// Bench with controller model, reference pixel queue and checks
`timescale 1ns/1ps
module testbench;
    logic        clk_in = 0, rstn_in = 0, h_mirror_in = 0, v_normal_in = 1, pc_p = 0, go = 0;
    logic [31:0] rnd = 55;
    logic [8:0]  cnt = 0;
    logic [35:0] q[$];
    int          miscompares = 0, n_checks = 0, nf = 0, nd = 0;
    wire         pixel_clock_in, line_sync_n_in, frame_sync_n_in, data_enable_strobe_in, pixel_valid_out;
    wire         frame_start_out, line_overrun_out, enable_short_out;
    wire  [3:0]  ln;
    wire  [8:0]  pixel_column_out, pixel_row_out;
    wire  [17:0] pixel_word_out;
    wire  [5:0]  red_level_in   = data_enable_strobe_in ? rnd[17:12] : 6'h00;
    wire  [5:0]  green_level_in = data_enable_strobe_in ? rnd[11:6] : 6'h00;
    wire  [5:0]  blue_level_in  = data_enable_strobe_in ? rnd[5:0] : 6'h00;
    always #2.5 clk_in = ~clk_in;
    rpv_ctl_model u_ctl (.clk_in(clk_in), .rstn_in(rstn_in), .ln_out(ln),
        .pins_out({pixel_clock_in, line_sync_n_in, frame_sync_n_in, data_enable_strobe_in}));
    rpv_panel_input #(.ACTIVE_LINES(2)) u_dut (
        .clk_in(clk_in), .rstn_in(rstn_in), .pixel_clock_in(pixel_clock_in),
        .line_sync_n_in(line_sync_n_in), .frame_sync_n_in(frame_sync_n_in),
        .data_enable_strobe_in(data_enable_strobe_in), .red_level_in(red_level_in),
        .green_level_in(green_level_in), .blue_level_in(blue_level_in), .h_mirror_in(h_mirror_in),
        .v_normal_in(v_normal_in), .pixel_valid_out(pixel_valid_out), .pixel_word_out(pixel_word_out),
        .pixel_column_out(pixel_column_out), .pixel_row_out(pixel_row_out),
        .frame_start_out(frame_start_out), .line_overrun_out(line_overrun_out),
        .enable_short_out(enable_short_out));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task chk(input logic [35:0] seen, want, input string nm);
        n_checks++;
        if (seen !== want) miscompares++;
        if (seen !== want) $display("mismatch %s expected %h seen %h", nm, want, seen);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Enable pulses on every line, so rows must come from the line count alone
    always @(posedge clk_in) begin
        pc_p <= pixel_clock_in;
        if (ln == 4'h0) go = 1;
        if (pc_p && !pixel_clock_in) rnd <= xs(rnd);
        if (!pc_p && pixel_clock_in) begin
            if (go && data_enable_strobe_in && ln > 4'h6 && ln < 4'h9 && cnt < 9'd320)
                q.push_back({rnd[17:0], h_mirror_in ? 9'd319 - cnt : cnt, v_normal_in ? 9'(ln) - 9'd7 : 9'd8 - 9'(ln)});
            cnt = data_enable_strobe_in ? cnt + 9'd1 : 9'd0;
        end
        nf += (frame_start_out === 1'b1);
        nd += (line_overrun_out === 1'b1) + (enable_short_out === 1'b1);
        if (pixel_valid_out === 1'b1) chk({pixel_word_out, pixel_column_out, pixel_row_out},
            q.size() ? q.pop_front() : 'x, "pixel");
    end
    initial begin
        repeat (3) @(posedge clk_in);
        rstn_in <= 1;
        // Second frame: mirrored and inverted; stop after its first active line to stay short
        wait (ln == 4'h0);
        wait (ln == 4'h8);
        wait (ln == 4'h0);
        h_mirror_in <= 1'b1;
        v_normal_in <= 1'b0;
        wait (ln == 4'h8);
        repeat (20) @(posedge clk_in);
        chk(q.size(), 0, "pixels left");
        chk(nf, 2, "frame starts");
        chk(nd, 0, "diagnostic pulses");
        tally_and_finish;
    end
    initial begin
        #510000 miscompares++;
        tally_and_finish;
    end
endmodule // testbench
